/* hdl/lss_sink_ctrl.sv */
// Purpose: Register bank and drive selection for high-voltage, parallel and colour sinks
// Assumes: Register port comes from the serial front end on clk_sys
// Notes: Drive levels are 9-bit codes in 0.15 mA units
`timescale 1ns/10ps
// Function
// (R1) High-voltage level fields: 8-bit code, 0.15 mA per step, FFh is 38.25 mA.
// (R2) High-voltage select: off, on, PWM gated, pattern gated.
// (R3) Parallel sinks use own level or shared flash/torch level by mode.
// (R4) Auto-off ends torch at strobe expiry; rewrite trigger off then on to restart.
// (R5) Torch trigger: off, software write, pin two high or low with enable.
// (R6) Flash double doubles parallel sink current only during strobe.
// (R7) Strobe pin select picks input pin and which sink group flashes.
// (R8) Strobe trigger: off, software write, selected pin high or low.
// (R9) Fixed mode holds flash for full duration; pin pulse needs 10 us.
// (R10) Capped mode follows trigger up to duration; follow mode tracks trigger.
// (R11) Strobe duration is 100 ms times code plus one.
// (R12) Shared flash level: 6-bit, 0.6 mA steps, doubled with flash double.
// (R13) Shared torch level: 6-bit, 0.6 mA steps, for strobe/preview sinks.
// (R14) Parallel select: off, strobe/preview, PWM gated, statically on.
// (R15) Software avoids shared alternate level in static mode with soft dimming.
// (R16) Sequence override bit hands a parallel sink to the pattern generator.
// (R17) Parallel sink three level: 8-bit, 0.15 mA steps, outside strobe use.
// (R18) Colour sink one level: 8-bit code, 0.15 mA per step.
// (R19) Pattern generator runs whenever any sink is connected to it.
// (R20) All fields reset to zero; every sink off, strobe and torch disabled.
module lss_sink_ctrl #(
    parameter int FLASH_STEP_CYCLES = lss_pkg::FLASH_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Configuration held elsewhere
    input wire logic pin_one_input_en,
    input wire logic pin_two_input_en,
    input wire logic par_zero_input_en,
    input wire logic [7:0] par_zero_level,
    input wire logic [7:0] par_one_level,
    input wire logic [7:0] par_two_level,
    input wire logic [7:0] shared_alt_level,
    input wire logic [3:0] par_alt_sel,
    // Sink pins used as inputs
    input wire logic hv_sink_one_pin,
    input wire logic hv_sink_two_pin,
    input wire logic par_sink_zero_pin,
    // Generator gates
    input wire logic pwm_gate,
    input wire logic seq_gate,
    // High-voltage sinks
    output logic [2:0] hv_on,
    output logic [7:0] hv_one_level,
    output logic [7:0] hv_two_level,
    output logic [7:0] hv_six_level,
    // Parallel and colour sinks
    output logic [3:0] par_on,
    output logic [3:0][lss_pkg::DRIVE_W-1:0] par_drive,
    output logic [7:0] color_one_level,
    // Status
    output logic flash_active,
    output logic torch_active,
    output logic seq_run
);
    if (FLASH_STEP_CYCLES < 2) begin : g_bad_param
        $error("lss_sink_ctrl: FLASH_STEP_CYCLES too small");
    end

    function automatic logic [3:0] reg_index(input logic [7:0] a);
        if (a == lss_pkg::ADDR_HV_MODE_A) reg_index = lss_pkg::IDX_HV_MODE_A;
        else if (a == lss_pkg::ADDR_HV_MODE_B) reg_index = lss_pkg::IDX_HV_MODE_B;
        else if (a == lss_pkg::ADDR_PAR_MODE) reg_index = lss_pkg::IDX_PAR_MODE;
        else if (a == lss_pkg::ADDR_HV_ONE) reg_index = lss_pkg::IDX_HV_ONE;
        else if (a == lss_pkg::ADDR_HV_TWO) reg_index = lss_pkg::IDX_HV_TWO;
        else if (a == lss_pkg::ADDR_COLOR_ONE) reg_index = lss_pkg::IDX_COLOR_ONE;
        else if (a == lss_pkg::ADDR_FLASH_LVL) reg_index = lss_pkg::IDX_FLASH_LVL;
        else if (a == lss_pkg::ADDR_TORCH_LVL) reg_index = lss_pkg::IDX_TORCH_LVL;
        else if (a == lss_pkg::ADDR_FLASH_TRIG) reg_index = lss_pkg::IDX_FLASH_TRIG;
        else if (a == lss_pkg::ADDR_OPTIONS) reg_index = lss_pkg::IDX_OPTIONS;
        else if (a == lss_pkg::ADDR_SEQ_OVR) reg_index = lss_pkg::IDX_SEQ_OVR;
        else if (a == lss_pkg::ADDR_HV_SIX) reg_index = lss_pkg::IDX_HV_SIX;
        else if (a == lss_pkg::ADDR_PAR_THREE) reg_index = lss_pkg::IDX_PAR_THREE;
        else reg_index = lss_pkg::IDX_NONE;
    endfunction

    // Trigger source decode, used for both strobe and torch
    function automatic logic trig_level(input logic [1:0] sel, input logic en, input logic pin);
        case (sel)
            lss_pkg::TRIG_SW: trig_level = 1'b1;
            lss_pkg::TRIG_HIGH: trig_level = en & pin;
            lss_pkg::TRIG_LOW: trig_level = en & ~pin;
            default: trig_level = 1'b0;
        endcase
    endfunction

    logic [7:0] regs [lss_pkg::NREG];
    logic [7:0] next_regs [lss_pkg::NREG];
    logic [7:0] next_rdata;
    logic [3:0] wr_idx, rd_idx;
    logic [2:0] pin_meta, pin_sync;
    logic torch_block, next_torch_block;
    logic flash_on, flash_timeout;

    assign wr_idx = reg_index(reg_addr);
    assign rd_idx = reg_index(reg_addr);

    // Register writes and reads
    always_comb begin
        for (int i = 0; i < lss_pkg::NREG; i++) begin
            next_regs[i] = regs[i];
        end
        if (reg_wr && wr_idx != lss_pkg::IDX_NONE) begin
            next_regs[wr_idx] = reg_wdata & lss_pkg::WMASK[wr_idx]; // R1 R17 R18
        end
        next_rdata = reg_rdata;
        if (reg_rd) begin
            // Unmapped addresses read as zero
            next_rdata = (rd_idx == lss_pkg::IDX_NONE) ? 8'h00 : regs[rd_idx];
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < lss_pkg::NREG; i++) begin
                regs[i] <= lss_pkg::REG_RESET; // R20
            end
            reg_rdata <= 8'h00;
        end else begin
            regs <= next_regs;
            reg_rdata <= next_rdata;
        end
    end

    // Pin inputs cross into clk_sys
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {par_sink_zero_pin, hv_sink_two_pin, hv_sink_one_pin};
            pin_sync <= pin_meta;
        end
    end

    // Field views
    logic [1:0] strobe_trig, strobe_mode, torch_trig;
    logic [3:0] strobe_time;
    logic auto_off, flash_double, strobe_pin, strobe_from_pin, strobe_trig_lvl, torch_req;
    logic [lss_pkg::SHARED_W-1:0] flash_lvl, torch_lvl;

    assign strobe_trig = regs[lss_pkg::IDX_FLASH_TRIG][lss_pkg::F_STROBE_TRIG +: 2];
    assign strobe_mode = regs[lss_pkg::IDX_FLASH_TRIG][lss_pkg::F_STROBE_MODE +: 2];
    assign strobe_time = regs[lss_pkg::IDX_FLASH_TRIG][lss_pkg::F_STROBE_TIME +: 4];
    assign auto_off = regs[lss_pkg::IDX_OPTIONS][lss_pkg::F_AUTO_OFF];
    assign torch_trig = regs[lss_pkg::IDX_OPTIONS][lss_pkg::F_TORCH_TRIG +: 2];
    assign flash_double = regs[lss_pkg::IDX_OPTIONS][lss_pkg::F_FLASH_DOUBLE];
    assign strobe_pin = regs[lss_pkg::IDX_OPTIONS][lss_pkg::F_STROBE_PIN];
    assign flash_lvl = regs[lss_pkg::IDX_FLASH_LVL][lss_pkg::SHARED_W-1:0];
    assign torch_lvl = regs[lss_pkg::IDX_TORCH_LVL][lss_pkg::SHARED_W-1:0];
    assign strobe_from_pin = strobe_trig[1];

    // Selected strobe input and its enable
    assign strobe_trig_lvl = strobe_pin ?
        trig_level(strobe_trig, par_zero_input_en, pin_sync[2]) :
        trig_level(strobe_trig, pin_one_input_en, pin_sync[0]); // R7 R8
    assign torch_req = trig_level(torch_trig, pin_two_input_en, pin_sync[1]); // R5

    lss_flash_timer #(
        .STEP_CYCLES(FLASH_STEP_CYCLES),
        .QUAL_CYCLES(lss_pkg::MIN_TRIG_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .reset(reset),
        .trig(strobe_trig_lvl),
        .trig_from_pin(strobe_from_pin),
        .mode(strobe_mode),
        .timing(strobe_time),
        .flash_on(flash_on),
        .flash_timeout(flash_timeout)
    );

    // Torch lockout after strobe expiry; expiry wins over a same-cycle off write
    always_comb begin
        next_torch_block = torch_block;
        if (reg_wr && wr_idx == lss_pkg::IDX_OPTIONS &&
            reg_wdata[lss_pkg::F_TORCH_TRIG +: 2] == lss_pkg::TRIG_OFF) begin
            next_torch_block = 1'b0;
        end
        if (flash_timeout && auto_off) begin
            next_torch_block = 1'b1; // R4
        end
    end

    // Sink drive selection
    logic [2:0] next_hv_on;
    logic [3:0] next_par_on;
    logic [3:0][lss_pkg::DRIVE_W-1:0] next_par_drive;
    logic next_torch, next_seq_run, hv_flash, par_flash;
    logic [7:0] own_lvl [4];
    logic [1:0] hv_sel [3];
    logic [lss_pkg::DRIVE_W-1:0] flash_drive, torch_drive;

    assign own_lvl[0] = par_zero_level;
    assign own_lvl[1] = par_one_level;
    assign own_lvl[2] = par_two_level;
    assign own_lvl[3] = regs[lss_pkg::IDX_PAR_THREE]; // R17
    assign hv_sel[0] = regs[lss_pkg::IDX_HV_MODE_A][lss_pkg::F_HV_ONE_SEL +: 2];
    assign hv_sel[1] = regs[lss_pkg::IDX_HV_MODE_A][lss_pkg::F_HV_TWO_SEL +: 2];
    assign hv_sel[2] = regs[lss_pkg::IDX_HV_MODE_B][lss_pkg::F_HV_SIX_SEL +: 2];

    // 0.6 mA steps are four 0.15 mA units; doubling makes it eight
    assign flash_drive = flash_double ? {flash_lvl, 3'b000} : {1'b0, flash_lvl, 2'b00}; // R6 R12
    assign torch_drive = {1'b0, torch_lvl, 2'b00}; // R13
    assign hv_flash = flash_on & strobe_pin & strobe_from_pin; // R7
    assign par_flash = flash_on & ~hv_flash;

    always_comb begin
        next_torch = torch_req & ~torch_block;
        next_seq_run = 1'b0;
        for (int i = 0; i < 3; i++) begin
            case (hv_sel[i])
                lss_pkg::HV_ON: next_hv_on[i] = 1'b1;
                lss_pkg::HV_PWM: next_hv_on[i] = pwm_gate;
                lss_pkg::HV_SEQ: next_hv_on[i] = seq_gate;
                default: next_hv_on[i] = 1'b0;
            endcase // R2
            next_hv_on[i] = next_hv_on[i] | hv_flash;
            next_seq_run = next_seq_run | (hv_sel[i] == lss_pkg::HV_SEQ); // R19
        end
        for (int j = 0; j < 4; j++) begin
            next_par_drive[j] = par_alt_sel[j] ? {1'b0, shared_alt_level} : {1'b0, own_lvl[j]};
            if (regs[lss_pkg::IDX_SEQ_OVR][lss_pkg::F_SEQ_OVR + j]) begin
                next_par_on[j] = seq_gate; // R16
                next_seq_run = 1'b1; // R19
            end else begin
                case (regs[lss_pkg::IDX_PAR_MODE][2*j +: 2])
                    lss_pkg::PAR_FLASH: begin
                        next_par_on[j] = par_flash | next_torch;
                        next_par_drive[j] = par_flash ? flash_drive : torch_drive; // R3
                    end
                    lss_pkg::PAR_PWM: next_par_on[j] = pwm_gate;
                    lss_pkg::PAR_ON: next_par_on[j] = 1'b1;
                    default: next_par_on[j] = 1'b0;
                endcase // R14
            end
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            torch_block <= 1'b0;
            hv_on <= 3'h0;
            par_on <= 4'h0;
            par_drive <= '0;
            torch_active <= 1'b0;
            seq_run <= 1'b0;
            flash_active <= 1'b0;
        end else begin
            torch_block <= next_torch_block;
            hv_on <= next_hv_on;
            par_on <= next_par_on;
            par_drive <= next_par_drive;
            torch_active <= next_torch;
            seq_run <= next_seq_run;
            flash_active <= flash_on;
        end
    end

    assign hv_one_level = regs[lss_pkg::IDX_HV_ONE]; // R1
    assign hv_two_level = regs[lss_pkg::IDX_HV_TWO];
    assign hv_six_level = regs[lss_pkg::IDX_HV_SIX];
    assign color_one_level = regs[lss_pkg::IDX_COLOR_ONE]; // R18

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    a_hv_off_mode: assert property ((hv_sel[0] == lss_pkg::HV_OFF && !hv_flash) |=> !hv_on[0]) // R2
        else $error("hv sink one driven while off");
    a_hv_static_on: assert property ((hv_sel[1] == lss_pkg::HV_ON) |=> hv_on[1]) // R2
        else $error("hv sink two not on in static mode");
    a_torch_lock: assert property ((flash_timeout && auto_off) |=> ##1 !torch_active) // R4
        else $error("torch still on after strobe expiry");
    a_torch_sw: assert property ((torch_trig == lss_pkg::TRIG_SW && !torch_block) |=> torch_active) // R5
        else $error("software torch did not start");
    a_flash_double: assert property ((flash_on && !hv_flash && flash_double &&
        regs[lss_pkg::IDX_PAR_MODE][1:0] == lss_pkg::PAR_FLASH && !regs[lss_pkg::IDX_SEQ_OVR][lss_pkg::F_SEQ_OVR])
        |=> par_drive[0] == $past(flash_drive)) // R6
        else $error("parallel sink zero flash level wrong");
    a_strobe_off: assert property ((strobe_trig == lss_pkg::TRIG_OFF && !flash_on) [*2] |=> !flash_on) // R8
        else $error("flash started with trigger off");
    a_pin_glitch: assert property ((strobe_mode == lss_pkg::SM_FIXED && strobe_from_pin && !flash_on
        && !strobe_trig_lvl ##1 strobe_trig_lvl [*3] ##1 !strobe_trig_lvl) |=> !flash_on) // R9
        else $error("short pin pulse fired the flash");
    a_follow_end: assert property ((flash_on && strobe_mode == lss_pkg::SM_FOLLOW && !strobe_trig_lvl) |=> !flash_on) // R10
        else $error("follow mode flash outlived trigger");
    a_seq_override: assert property (regs[lss_pkg::IDX_SEQ_OVR][lss_pkg::F_SEQ_OVR + 3] |=> seq_run) // R19
        else $error("pattern generator not running");
    a_unmapped_read: assert property ((reg_rd && rd_idx == lss_pkg::IDX_NONE) |=> reg_rdata == 8'h00) // R20
        else $error("unmapped read not zero");

    c_flash_timeout: cover property (flash_timeout);
    c_torch_on: cover property (torch_active);
    c_hv_flash: cover property (flash_on && hv_flash);
endmodule // lss_sink_ctrl

/* hdl/lss_pkg.sv */
// Purpose: Shared constants and types for the sink and strobe control block
// Assumes: 250 MHz system clock, 8-bit register port from the serial front end
// Notes: Register indexes select storage slots; offsets are the byte addresses
package lss_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_HV_MODE_A = 8'h01;
    localparam logic [7:0] ADDR_HV_MODE_B = 8'h02;
    localparam logic [7:0] ADDR_PAR_MODE = 8'h03;
    localparam logic [7:0] ADDR_HV_ONE = 8'h09;
    localparam logic [7:0] ADDR_HV_TWO = 8'h0a;
    localparam logic [7:0] ADDR_COLOR_ONE = 8'h0b;
    localparam logic [7:0] ADDR_FLASH_LVL = 8'h0e;
    localparam logic [7:0] ADDR_TORCH_LVL = 8'h0f;
    localparam logic [7:0] ADDR_FLASH_TRIG = 8'h11;
    localparam logic [7:0] ADDR_OPTIONS = 8'h12;
    localparam logic [7:0] ADDR_SEQ_OVR = 8'h18;
    localparam logic [7:0] ADDR_HV_SIX = 8'h2f;
    localparam logic [7:0] ADDR_PAR_THREE = 8'h43;

    // Storage slot of each register
    localparam int NREG = 13;
    localparam logic [3:0] IDX_HV_MODE_A = 4'h0;
    localparam logic [3:0] IDX_HV_MODE_B = 4'h1;
    localparam logic [3:0] IDX_PAR_MODE = 4'h2;
    localparam logic [3:0] IDX_HV_ONE = 4'h3;
    localparam logic [3:0] IDX_HV_TWO = 4'h4;
    localparam logic [3:0] IDX_COLOR_ONE = 4'h5;
    localparam logic [3:0] IDX_FLASH_LVL = 4'h6;
    localparam logic [3:0] IDX_TORCH_LVL = 4'h7;
    localparam logic [3:0] IDX_FLASH_TRIG = 4'h8;
    localparam logic [3:0] IDX_OPTIONS = 4'h9;
    localparam logic [3:0] IDX_SEQ_OVR = 4'ha;
    localparam logic [3:0] IDX_HV_SIX = 4'hb;
    localparam logic [3:0] IDX_PAR_THREE = 4'hc;
    localparam logic [3:0] IDX_NONE = 4'hf;

    // Implemented bits; all others read as zero
    localparam logic [7:0] WMASK [NREG] = '{8'h0f, 8'hc0, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f,
                                           8'h3f, 8'hff, 8'ha7, 8'hf0, 8'hff, 8'hff};
    localparam logic [7:0] REG_RESET = 8'h00;

    // Field positions
    localparam int F_HV_ONE_SEL = 0;
    localparam int F_HV_TWO_SEL = 2;
    localparam int F_HV_SIX_SEL = 6;
    localparam int F_STROBE_TRIG = 0;
    localparam int F_STROBE_MODE = 2;
    localparam int F_STROBE_TIME = 4;
    localparam int F_AUTO_OFF = 0;
    localparam int F_TORCH_TRIG = 1;
    localparam int F_FLASH_DOUBLE = 5;
    localparam int F_STROBE_PIN = 7;
    localparam int F_SEQ_OVR = 4;
    localparam int SHARED_W = 6;
    localparam int DRIVE_W = 9;

    // Timing
    localparam int CLK_MHZ = 250;
    localparam int FLASH_STEP_MS = 100;
    localparam int FLASH_STEP_CYCLES = FLASH_STEP_MS * CLK_MHZ * 1000;
    localparam int MIN_TRIG_US = 10;
    localparam int MIN_TRIG_CYCLES = MIN_TRIG_US * CLK_MHZ;

    typedef enum logic [1:0] {HV_OFF = 2'b00, HV_ON = 2'b01, HV_PWM = 2'b10, HV_SEQ = 2'b11} lss_hv_mode_t;
    typedef enum logic [1:0] {PAR_OFF = 2'b00, PAR_FLASH = 2'b01, PAR_PWM = 2'b10, PAR_ON = 2'b11} lss_par_mode_t;
    typedef enum logic [1:0] {TRIG_OFF = 2'b00, TRIG_SW = 2'b01, TRIG_HIGH = 2'b10, TRIG_LOW = 2'b11} lss_trig_t;
    typedef enum logic [1:0] {SM_FIXED = 2'b00, SM_CAPPED = 2'b01, SM_FOLLOW = 2'b10, SM_UNUSED = 2'b11} lss_smode_t;
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_QUAL = 2'b01, ST_FLASH = 2'b10, ST_HOLD = 2'b11} lss_fstate_t;
endpackage

/* hdl/lss_flash_timer.sv */
// Purpose: Strobe duration state machine for the three strobe modes
// Assumes: trig is already synchronised and qualified by source selection
// Notes: Duration restarts from zero at each flash start, so it is exact
`timescale 1ns/10ps
module lss_flash_timer #(
    parameter int STEP_CYCLES = lss_pkg::FLASH_STEP_CYCLES,
    parameter int QUAL_CYCLES = lss_pkg::MIN_TRIG_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Trigger and settings
    input wire logic trig,
    input wire logic trig_from_pin,
    input wire logic [1:0] mode,
    input wire logic [3:0] timing,
    // Status
    output logic flash_on,
    output logic flash_timeout
);
    localparam int TW = $clog2(STEP_CYCLES + 1);
    localparam int QW = $clog2(QUAL_CYCLES + 1);

    if (STEP_CYCLES < 2 || QUAL_CYCLES < 1) begin : g_bad_param
        $error("lss_flash_timer: counts too small");
    end

    lss_pkg::lss_fstate_t st, next_st;
    logic [TW-1:0] tick, next_tick;
    logic [QW-1:0] qual, next_qual;
    logic [3:0] steps, next_steps;
    logic next_flash_on, next_timeout;

    always_comb begin
        next_st = st;
        next_tick = tick;
        next_qual = qual;
        next_steps = steps;
        next_timeout = 1'b0;
        case (st)
            lss_pkg::ST_IDLE: begin
                next_tick = '0;
                next_steps = '0;
                next_qual = '0;
                if (trig && mode != lss_pkg::SM_UNUSED) begin
                    if (mode == lss_pkg::SM_FIXED && trig_from_pin) begin
                        next_st = lss_pkg::ST_QUAL; // R9
                    end else begin
                        next_st = lss_pkg::ST_FLASH;
                    end
                end
            end
            lss_pkg::ST_QUAL: begin
                // Short glitches on the pin never fire a fixed-mode flash
                if (!trig) begin
                    next_st = lss_pkg::ST_IDLE; // R9
                end else if (qual == QW'(QUAL_CYCLES - 1)) begin
                    next_st = lss_pkg::ST_FLASH;
                end else begin
                    next_qual = qual + QW'(1);
                end
            end
            lss_pkg::ST_FLASH: begin
                if (tick == TW'(STEP_CYCLES - 1)) begin
                    next_tick = '0;
                    next_steps = steps + 4'h1;
                end else begin
                    next_tick = tick + TW'(1);
                end
                if (mode != lss_pkg::SM_FIXED && !trig) begin
                    next_st = lss_pkg::ST_IDLE; // R10
                end else if (mode != lss_pkg::SM_FOLLOW && tick == TW'(STEP_CYCLES - 1) && steps == timing) begin
                    next_st = lss_pkg::ST_HOLD; // R11
                    next_timeout = 1'b1;
                end
            end
            default: begin
                // Wait for the trigger to drop before arming again
                if (!trig) begin
                    next_st = lss_pkg::ST_IDLE;
                end
            end
        endcase
        next_flash_on = (next_st == lss_pkg::ST_FLASH);
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= lss_pkg::ST_IDLE;
            tick <= '0;
            qual <= '0;
            steps <= '0;
            flash_on <= 1'b0;
            flash_timeout <= 1'b0;
        end else begin
            st <= next_st;
            tick <= next_tick;
            qual <= next_qual;
            steps <= next_steps;
            flash_on <= next_flash_on;
            flash_timeout <= next_timeout;
        end
    end
endmodule // lss_flash_timer

/* verification/lss_host_model.sv */
// Purpose: Host side of the register port for the bench
// Assumes: One byte per access, one-cycle strobes
// Notes: Write data is inverted once released, so stale data never looks valid
`timescale 1ns/10ps
module lss_host_model (
    // Clock
    input wire logic clk_sys,
    // Register port
    output logic [7:0] reg_addr = 8'h00,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0,
    input wire logic [7:0] reg_rdata
);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // Read data is registered: take it just after the accepting edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule // lss_host_model

/* verification/lss_sink_ctrl_test.sv */
// Purpose: Self-checking bench for the sink and strobe control block
// Assumes: Strobe step shortened to STEP cycles
// Notes: Triggers stay off or on software while pin levels are random; the last test triggers from pin one
`timescale 1ns/10ps
module lss_sink_ctrl_test;
    localparam int STEP = 50;
    localparam logic [7:0] ADR [13] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'h11, 8'h12,
                                        8'h18, 8'h2f, 8'h43};
    localparam logic [7:0] FCTL [3] = '{8'h01, 8'h15, 8'h0d};
    localparam int FRISE [3] = '{2, 2, 10};
    localparam int FLEN [3] = '{STEP, 2 * STEP, 0};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, v;
    logic reg_wr, reg_rd, pin_one_input_en = 1'b0, pin_two_input_en = 1'b0, par_zero_input_en = 1'b0;
    logic [7:0] par_zero_level = 8'h00, par_one_level = 8'h00, par_two_level = 8'h00, shared_alt_level = 8'h00;
    logic [3:0] par_alt_sel = 4'h0;
    logic hv_sink_one_pin = 1'b0, hv_sink_two_pin = 1'b0, par_sink_zero_pin = 1'b0, pwm_gate = 1'b0, seq_gate = 1'b0;
    logic [2:0] hv_on;
    logic [7:0] hv_one_level, hv_two_level, hv_six_level, color_one_level;
    logic [3:0] par_on;
    logic [3:0][lss_pkg::DRIVE_W-1:0] par_drive;
    logic flash_active, torch_active, seq_run;
    logic [7:0] vals [13];
    int n_mismatch = 0, checks_done = 0, cyc = 0, seed = 89667, rise, len;
    lss_host_model host (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    lss_sink_ctrl #(.FLASH_STEP_CYCLES(STEP)) DUT (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_one_input_en, .pin_two_input_en, .par_zero_input_en, .par_zero_level, .par_one_level,
        .par_two_level, .shared_alt_level, .par_alt_sel, .hv_sink_one_pin, .hv_sink_two_pin, .par_sink_zero_pin,
        .pwm_gate, .seq_gate, .hv_on, .hv_one_level, .hv_two_level, .hv_six_level, .par_on, .par_drive,
        .color_one_level, .flash_active, .torch_active, .seq_run);
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [8:0] shared_exp(input logic [7:0] c, input logic dbl);
        return dbl ? {c[5:0], 3'b000} : {1'b0, c[5:0], 2'b00};
    endfunction
    function automatic logic hv_exp(input logic [1:0] m, input logic p, input logic s);
        return (m == 2'b01) | ((m == 2'b10) & p) | ((m == 2'b11) & s);
    endfunction
    task automatic stim();
        @(posedge clk_sys);
        {pin_one_input_en, pin_two_input_en, par_zero_input_en, hv_sink_one_pin, hv_sink_two_pin} <= 5'($random(seed));
        {par_sink_zero_pin, pwm_gate, seq_gate, par_alt_sel} <= 7'($random(seed)) & 7'h77;
        {par_zero_level, par_one_level, par_two_level, shared_alt_level} <= $random(seed);
    endtask
    task automatic strobe(input logic [7:0] ctl, input logic [8:0] exp, output int r, output int n);
        host.wr(8'h11, 8'h00);
        host.wr(8'h11, ctl);
        r = 0;
        n = 0;
        while (flash_active !== 1'b1 && r < 10) begin
            tick(1);
            r++;
        end
        while (flash_active === 1'b1 && n < 2000) begin
            if (n == 5)
                chk(par_drive[0], exp);
            tick(1);
            n++;
        end
    endtask
    task automatic report_and_stop();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        for (int i = 0; i < 13; i++) begin
            host.rd(ADR[i], d);
            chk(d, 8'h00);
            vals[i] = 8'($random(seed));
            host.wr(ADR[i], vals[i]);
            host.rd(ADR[i], d);
            chk(d, vals[i] & lss_pkg::WMASK[i]);
        end
        chk(hv_one_level, vals[3]);
        chk(hv_two_level, vals[4]);
        chk(hv_six_level, vals[11]);
        chk(color_one_level, vals[5]);
        host.wr(8'h20, 8'hff);
        host.rd(8'h20, d);
        chk(d, 8'h00);
        for (int i = 0; i < 13; i++)
            host.wr(ADR[i], 8'h00);
        // A random fixed-mode flash may still run its full length
        tick(900);
        for (int j = 0; j < 8; j++) begin
            stim();
            host.wr(8'h01, {4'h0, j[1:0], j[1:0]});
            host.wr(8'h02, {j[1:0], 6'h00});
            tick(4);
            chk(hv_on, {3{hv_exp(j[1:0], pwm_gate, seq_gate)}});
            chk(seq_run, j[1:0] == 2'b11);
        end
        host.wr(8'h03, 8'hc1);
        v = 8'($random(seed));
        host.wr(8'h43, v);
        tick(4);
        chk(par_on[3], 1'b1);
        chk(par_drive[3], {1'b0, v});
        host.wr(8'h18, 8'h80);
        tick(4);
        chk(par_on[3], seq_gate);
        host.wr(8'h18, 8'h00);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            host.wr(8'h0e, v);
            host.wr(8'h12, {2'b00, i[0], 5'h00});
            strobe(FCTL[i], shared_exp(v, i[0]), rise, len);
            chk(9'(rise), 9'(FRISE[i]));
            chk(9'(len), 9'(FLEN[i]));
        end
        v = 8'($random(seed));
        host.wr(8'h0f, v);
        host.wr(8'h12, 8'h03);
        tick(3);
        chk(torch_active, 1'b1);
        chk(par_drive[0], {1'b0, v[5:0], 2'b00});
        host.wr(8'h0e, 8'h3f);
        strobe(8'h01, shared_exp(8'h3f, 1'b0), rise, len);
        tick(2);
        chk(torch_active, 1'b0);
        host.wr(8'h12, 8'h01);
        host.wr(8'h12, 8'h03);
        tick(3);
        chk(torch_active, 1'b1);
        host.wr(8'h11, 8'h0a);
        {pin_one_input_en, hv_sink_one_pin} <= 2'b10;
        tick(4);
        @(posedge clk_sys) hv_sink_one_pin <= 1'b1;
        tick(20);
        chk(flash_active, 1'b1);
        @(posedge clk_sys) hv_sink_one_pin <= 1'b0;
        tick(6);
        chk(flash_active, 1'b0);
        report_and_stop();
    end
endmodule // lss_sink_ctrl_test
